// ==== core/port_group_pin_config_pkg.sv ====
// Constants shared by the port group pin configuration block
package port_group_pin_config_pkg;

    // ************************************************************
    // Register byte offsets (one aligned 32-bit word each)
    // ************************************************************
    localparam logic [7:0] OFS_G0_DATA             = 8'h00;
    localparam logic [7:0] OFS_G0_IO_ENABLE        = 8'h04;
    localparam logic [7:0] OFS_G0_PULL_CONTROL     = 8'h08;
    localparam logic [7:0] OFS_G0_IRQ_FLAGS        = 8'h0C;
    localparam logic [7:0] OFS_G0_IRQ_CONTROL      = 8'h10;
    localparam logic [7:0] OFS_G0_DEBOUNCE_ENABLE  = 8'h14;
    localparam logic [7:0] OFS_G0_MODE_SELECT      = 8'h18;
    localparam logic [7:0] OFS_G0_FUNCTION_SELECT  = 8'h1C;
    localparam logic [7:0] OFS_G1_DATA             = 8'h20;
    localparam logic [7:0] OFS_G1_IO_ENABLE        = 8'h24;
    localparam logic [7:0] OFS_G1_PULL_CONTROL     = 8'h28;
    localparam logic [7:0] OFS_G1_IRQ_FLAGS        = 8'h2C;
    localparam logic [7:0] OFS_G1_IRQ_CONTROL      = 8'h30;
    localparam logic [7:0] OFS_G1_DEBOUNCE_ENABLE  = 8'h34;
    localparam logic [7:0] OFS_G1_MODE_SELECT      = 8'h38;
    localparam logic [7:0] OFS_G1_FUNCTION_SELECT  = 8'h3C;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int          G0_HI_LSB   = 8;
    localparam int          G1_HI_LSB   = 12;
    localparam int          G1_LO_LSB   = 4;
    localparam logic [7:0]  RST_BYTE    = 8'h00;
    localparam logic [3:0]  RST_NIBBLE  = 4'h0;
    localparam logic [15:0] RST_WORD    = 16'h0000;

    // ************************************************************
    // Function assignment maps {f3,f2,f1,f0}, one bit per pin
    // ************************************************************
    localparam logic [31:0] G0_FUNC_MAP  = 32'h0780_FFFF;
    localparam logic [31:0] G1_FUNC_MAP  = 32'h0FE0_0F1F;
    localparam logic [15:0] GPIO_CAPABLE = 16'hF0FF;

    // ************************************************************
    // Debounce filter defaults
    // ************************************************************
    localparam int DEB_DIV_DEFAULT = 16;
    localparam int DEB_LEN_DEFAULT = 4;

endpackage : port_group_pin_config_pkg

// ==== core/port_group_pin_config.sv ====
// Pin configuration and GPIO logic for port groups 0 and 1, interrupt and debounce logic for group 0 only
//
// The Avalon-MM interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
module port_group_pin_config
    import port_group_pin_config_pkg::*;
#(
    parameter int DEBOUNCE_DIV = DEB_DIV_DEFAULT,
    parameter int DEBOUNCE_LEN = DEB_LEN_DEFAULT
) (
    input  wire logic        I_CLK,
    input  wire logic        I_RESET,
    input  wire logic [7:0]  I_AVS_ADDRESS,
    input  wire logic        I_AVS_READ,
    input  wire logic        I_AVS_WRITE,
    input  wire logic [31:0] I_AVS_WRITEDATA,
    input  wire logic [3:0]  I_AVS_BYTEENABLE,
    output logic      [31:0] O_AVS_READDATA,
    output logic             O_AVS_WAITREQUEST,
    input  wire logic [7:0]  I_G0_PIN_IN,
    input  wire logic [7:0]  I_G1_PIN_IN,
    input  wire logic [31:0] I_G0_PERIPH_OUT,
    input  wire logic [31:0] I_G0_PERIPH_OE,
    input  wire logic [31:0] I_G1_PERIPH_OUT,
    input  wire logic [31:0] I_G1_PERIPH_OE,
    output logic      [7:0]  O_G0_PIN_OUT,
    output logic      [7:0]  O_G0_PIN_OE,
    output logic      [7:0]  O_G0_PULL_ON,
    output logic      [7:0]  O_G0_PULL_UP,
    output logic      [7:0]  O_G0_INBUF_ON,
    output logic      [7:0]  O_G1_PIN_OUT,
    output logic      [7:0]  O_G1_PIN_OE,
    output logic      [3:0]  O_G1_PULL_ON,
    output logic      [3:0]  O_G1_PULL_UP,
    output logic      [3:0]  O_G1_INBUF_ON,
    output logic      [31:0] O_G0_PERIPH_IN,
    output logic      [31:0] O_G1_PERIPH_IN,
    output logic             O_IRQ
);

    // ************************************************************
    // Parameter checks
    // ************************************************************
    if (DEBOUNCE_DIV < 1 || DEBOUNCE_DIV > 65535) begin : g_bad_div
        $error("DEBOUNCE_DIV must lie in 1..65535");
    end
    if (DEBOUNCE_LEN < 1 || DEBOUNCE_LEN > 15) begin : g_bad_len
        $error("DEBOUNCE_LEN must lie in 1..15");
    end

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [15:0] merge16(input logic [15:0] cur,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
        merge16 = {be[1] ? wd[15:8] : cur[15:8], be[0] ? wd[7:0] : cur[7:0]};
    endfunction : merge16

    // ************************************************************
    // Register state
    // ************************************************************
    logic [7:0]  g0_out_value;
    logic [7:0]  g0_input_buffer_on;
    logic [7:0]  g0_output_driver_on;
    logic [7:0]  g0_pull_direction;
    logic [7:0]  g0_pull_on;
    logic [7:0]  g0_irq_flag;
    logic [7:0]  g0_edge_pick;
    logic [7:0]  g0_irq_allow;
    logic [7:0]  g0_debounce_on;
    logic [7:0]  g0_peripheral_mode;
    logic [15:0] g0_function_code;
    logic [3:0]  g1_out_value;
    logic [3:0]  g1_input_buffer_on;
    logic [3:0]  g1_output_driver_on;
    logic [3:0]  g1_pull_direction;
    logic [3:0]  g1_pull_on;
    logic [7:0]  g1_peripheral_mode;
    logic [15:0] g1_function_code;

    // ************************************************************
    // Avalon-MM slave: one wait state, then one answer cycle
    // ************************************************************
    logic        ack;
    logic        next_ack;
    logic        wr_go;
    logic        rd_go;
    logic [15:0] rd_word;
    logic [15:0] wv;

    assign next_ack = (I_AVS_READ | I_AVS_WRITE) & ~ack;
    // Writes land on the edge where waitrequest is seen low
    assign wr_go    = I_AVS_WRITE & ack;
    assign rd_go    = I_AVS_READ & ~ack;

    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            ack               <= 1'b0;
            O_AVS_WAITREQUEST <= 1'b1;
        end else begin
            ack               <= next_ack;
            O_AVS_WAITREQUEST <= ~next_ack;
        end
    end

    // ************************************************************
    // Input synchronisers, three stages, settle on 2nd/3rd agreement
    // ************************************************************
    logic [15:0] sync1;
    logic [15:0] sync2;
    logic [15:0] sync3;
    logic [15:0] level;

    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            sync1 <= RST_WORD;
            sync2 <= RST_WORD;
            sync3 <= RST_WORD;
            level <= RST_WORD;
        end else begin
            sync1 <= {I_G1_PIN_IN, I_G0_PIN_IN};
            sync2 <= sync1;
            sync3 <= sync2;
            level <= (sync2 & ~(sync2 ^ sync3)) | (level & (sync2 ^ sync3));
        end
    end

    // ************************************************************
    // Debounce filter, group 0 only
    // ************************************************************
    logic [15:0] div_cnt;
    logic        deb_tick;
    logic [7:0]  deb_out;
    logic [7:0]  g0_cond;

    assign deb_tick = (div_cnt == 16'(DEBOUNCE_DIV - 1));

    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            div_cnt <= RST_WORD;
        end else begin
            div_cnt <= deb_tick ? RST_WORD : div_cnt + 16'h0001;
        end
    end

    // Glitches shorter than DEBOUNCE_LEN ticks never reach the flags
    // Each filter owns its output flop so that no vector has several process drivers
    for (genvar d = 0; d < 8; d++) begin : g_deb
        logic [3:0] stable_cnt;
        logic       filt;
        always_ff @(posedge I_CLK or posedge I_RESET) begin
            if (I_RESET) begin
                stable_cnt <= RST_NIBBLE;
                filt       <= 1'b0;
            end else if (level[d] == filt) begin
                stable_cnt <= RST_NIBBLE;
            end else if (deb_tick) begin
                if (stable_cnt == 4'(DEBOUNCE_LEN - 1)) begin
                    stable_cnt <= RST_NIBBLE;
                    filt       <= level[d];
                end else begin
                    stable_cnt <= stable_cnt + 4'h1;
                end
            end
        end
        assign deb_out[d] = filt;
    end

    assign g0_cond = (g0_debounce_on & deb_out) | (~g0_debounce_on & level[7:0]);

    // ************************************************************
    // Input data, edge detection and interrupt flags
    // ************************************************************
    logic [7:0] g0_in_value;
    logic [3:0] g1_in_value;
    logic [7:0] g0_in_prev;
    logic [7:0] g0_edge_event;
    logic [7:0] g0_flag_clear;
    logic [7:0] next_g0_irq_flag;

    assign g0_in_value = g0_cond & g0_input_buffer_on;
    assign g1_in_value = level[15:12] & g1_input_buffer_on;
    // Edge select one picks falling edges, zero rising edges
    assign g0_edge_event = (g0_edge_pick & g0_in_prev & ~g0_in_value)
                         | (~g0_edge_pick & ~g0_in_prev & g0_in_value);
    assign g0_flag_clear = (wr_go && I_AVS_ADDRESS == OFS_G0_IRQ_FLAGS && I_AVS_BYTEENABLE[0])
                         ? I_AVS_WRITEDATA[7:0] : RST_BYTE;
    // A new edge in the clearing cycle survives the clear
    assign next_g0_irq_flag = (g0_irq_flag & ~g0_flag_clear) | g0_edge_event;

    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            g0_in_prev  <= RST_BYTE;
            g0_irq_flag <= RST_BYTE;
            O_IRQ       <= 1'b0;
        end else begin
            g0_in_prev  <= g0_in_value;
            g0_irq_flag <= next_g0_irq_flag;
            O_IRQ       <= |(g0_irq_flag & g0_irq_allow);
        end
    end

    // ************************************************************
    // Register writes
    // ************************************************************
    assign wv = merge16(rd_word, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);

    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            g0_out_value        <= RST_BYTE;
            g0_input_buffer_on  <= RST_BYTE;
            g0_output_driver_on <= RST_BYTE;
            g0_pull_direction   <= RST_BYTE;
            g0_pull_on          <= RST_BYTE;
            g0_edge_pick        <= RST_BYTE;
            g0_irq_allow        <= RST_BYTE;
            g0_debounce_on      <= RST_BYTE;
            g0_peripheral_mode  <= RST_BYTE;
            g0_function_code    <= RST_WORD;
            g1_out_value        <= RST_NIBBLE;
            g1_input_buffer_on  <= RST_NIBBLE;
            g1_output_driver_on <= RST_NIBBLE;
            g1_pull_direction   <= RST_NIBBLE;
            g1_pull_on          <= RST_NIBBLE;
            g1_peripheral_mode  <= RST_BYTE;
            g1_function_code    <= RST_WORD;
        end else if (wr_go) begin
            case (I_AVS_ADDRESS)
                OFS_G0_DATA: begin
                    g0_out_value <= wv[15:8];
                end
                OFS_G0_IO_ENABLE: begin
                    g0_input_buffer_on  <= wv[15:8];
                    g0_output_driver_on <= wv[7:0];
                end
                OFS_G0_PULL_CONTROL: begin
                    g0_pull_direction <= wv[15:8];
                    g0_pull_on        <= wv[7:0];
                end
                OFS_G0_IRQ_CONTROL: begin
                    g0_edge_pick <= wv[15:8];
                    g0_irq_allow <= wv[7:0];
                end
                OFS_G0_DEBOUNCE_ENABLE: begin
                    g0_debounce_on <= wv[7:0];
                end
                OFS_G0_MODE_SELECT: begin
                    g0_peripheral_mode <= wv[7:0];
                end
                OFS_G0_FUNCTION_SELECT: begin
                    g0_function_code <= wv;
                end
                OFS_G1_DATA: begin
                    g1_out_value <= wv[15:12];
                end
                OFS_G1_IO_ENABLE: begin
                    g1_input_buffer_on  <= wv[15:12];
                    g1_output_driver_on <= wv[7:4];
                end
                OFS_G1_PULL_CONTROL: begin
                    g1_pull_direction <= wv[15:12];
                    g1_pull_on        <= wv[7:4];
                end
                OFS_G1_MODE_SELECT: begin
                    g1_peripheral_mode <= wv[7:0];
                end
                OFS_G1_FUNCTION_SELECT: begin
                    g1_function_code <= wv;
                end
                default: begin
                end
            endcase
        end
    end

    // ************************************************************
    // Register read image; unmapped and reserved read zero
    // ************************************************************
    always_comb begin
        case (I_AVS_ADDRESS)
            OFS_G0_DATA:            rd_word = {g0_out_value, g0_in_value};
            OFS_G0_IO_ENABLE:       rd_word = {g0_input_buffer_on, g0_output_driver_on};
            OFS_G0_PULL_CONTROL:    rd_word = {g0_pull_direction, g0_pull_on};
            OFS_G0_IRQ_FLAGS:       rd_word = {RST_BYTE, g0_irq_flag};
            OFS_G0_IRQ_CONTROL:     rd_word = {g0_edge_pick, g0_irq_allow};
            OFS_G0_DEBOUNCE_ENABLE: rd_word = {RST_BYTE, g0_debounce_on};
            OFS_G0_MODE_SELECT:     rd_word = {RST_BYTE, g0_peripheral_mode};
            OFS_G0_FUNCTION_SELECT: rd_word = g0_function_code;
            OFS_G1_DATA:            rd_word = {g1_out_value, RST_NIBBLE,
                                               g1_in_value, RST_NIBBLE};
            OFS_G1_IO_ENABLE:       rd_word = {g1_input_buffer_on, RST_NIBBLE,
                                               g1_output_driver_on, RST_NIBBLE};
            OFS_G1_PULL_CONTROL:    rd_word = {g1_pull_direction, RST_NIBBLE,
                                               g1_pull_on, RST_NIBBLE};
            OFS_G1_MODE_SELECT:     rd_word = {RST_BYTE, g1_peripheral_mode};
            OFS_G1_FUNCTION_SELECT: rd_word = g1_function_code;
            default:                rd_word = RST_WORD;
        endcase
    end

    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            O_AVS_READDATA <= {RST_WORD, RST_WORD};
        end else if (rd_go) begin
            O_AVS_READDATA <= {RST_WORD, rd_word};
        end
    end

    // ************************************************************
    // Pin routing, sixteen pins, group 1 at indices 8..15
    // ************************************************************
    logic [15:0] mode16;
    logic [31:0] fcode32;
    logic [15:0] gpio_out16;
    logic [15:0] gpio_oe16;
    logic [63:0] pout64;
    logic [63:0] poe64;
    logic [63:0] map64;
    logic [15:0] next_pin_out;
    logic [15:0] next_pin_oe;
    logic [63:0] next_periph_in;

    assign mode16     = {g1_peripheral_mode, g0_peripheral_mode};
    assign fcode32    = {g1_function_code, g0_function_code};
    assign gpio_out16 = {g1_out_value, RST_NIBBLE, g0_out_value} & GPIO_CAPABLE;
    assign gpio_oe16  = {g1_output_driver_on, RST_NIBBLE, g0_output_driver_on} & GPIO_CAPABLE;
    assign pout64     = {I_G1_PERIPH_OUT, I_G0_PERIPH_OUT};
    assign poe64      = {I_G1_PERIPH_OE, I_G0_PERIPH_OE};
    // Group 1 pins 0-3: f0 serial data-in/out/clock/select, f3 segments 3-6
    assign map64      = {G1_FUNC_MAP, G0_FUNC_MAP};

    for (genvar p = 0; p < 16; p++) begin : g_pin
        localparam int BASE = (p / 8) * 32 + (p % 8);
        logic [1:0] code;
        logic [5:0] idx;
        assign code = fcode32[2 * p + 1 -: 2];
        assign idx  = 6'(BASE) + {1'b0, code, 3'b000};
        // Unmapped codes leave the driver off                                       
        assign next_pin_out[p] = mode16[p] ? (map64[idx] & pout64[idx])
                                           : gpio_out16[p];
        assign next_pin_oe[p]  = mode16[p] ? (map64[idx] & poe64[idx])
                                           : gpio_oe16[p];
        for (genvar f = 0; f < 4; f++) begin : g_fn
            assign next_periph_in[BASE + f * 8] = mode16[p] && code == 2'(f)
                                                  && map64[BASE + f * 8] && level[p];
        end
    end

    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            O_G0_PIN_OUT   <= RST_BYTE;
            O_G0_PIN_OE    <= RST_BYTE;
            O_G1_PIN_OUT   <= RST_BYTE;
            O_G1_PIN_OE    <= RST_BYTE;
            O_G0_PERIPH_IN <= {RST_WORD, RST_WORD};
            O_G1_PERIPH_IN <= {RST_WORD, RST_WORD};
            O_G0_PULL_ON   <= RST_BYTE;
            O_G0_PULL_UP   <= RST_BYTE;
            O_G0_INBUF_ON  <= RST_BYTE;
            O_G1_PULL_ON   <= RST_NIBBLE;
            O_G1_PULL_UP   <= RST_NIBBLE;
            O_G1_INBUF_ON  <= RST_NIBBLE;
        end else begin
            O_G0_PIN_OUT   <= next_pin_out[7:0];
            O_G0_PIN_OE    <= next_pin_oe[7:0];
            O_G1_PIN_OUT   <= next_pin_out[15:8];
            O_G1_PIN_OE    <= next_pin_oe[15:8];
            O_G0_PERIPH_IN <= next_periph_in[31:0];
            O_G1_PERIPH_IN <= next_periph_in[63:32];
            O_G0_PULL_ON   <= g0_pull_on;
            O_G0_PULL_UP   <= g0_pull_direction;
            O_G0_INBUF_ON  <= g0_input_buffer_on;
            O_G1_PULL_ON   <= g1_pull_on;
            O_G1_PULL_UP   <= g1_pull_direction;
            O_G1_INBUF_ON  <= g1_input_buffer_on;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RESET);

    sequence s_req;
        (I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST && !ack;
    endsequence
    sequence s_answer;
        !O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST;
    endsequence

    a_bus_one_wait: assert property (s_req |=> s_answer)
        else $error("waitrequest did not drop for exactly one cycle");
    a_flag_set_wins: assert property (g0_edge_event[0] |=> g0_irq_flag[0])
        else $error("edge event lost against a clear");
    a_flag_clear_one: assert property (g0_flag_clear[1] && !g0_edge_event[1]
        |=> !g0_irq_flag[1])
        else $error("flag not cleared by writing one");
    a_irq_follows_flags: assert property (##1 O_IRQ == $past(|(g0_irq_flag & g0_irq_allow)))
        else $error("interrupt output does not follow enabled flags");
    a_in_data_read: assert property (rd_go && I_AVS_ADDRESS == OFS_G0_DATA
        |=> O_AVS_READDATA[7:0] == $past(g0_in_value))
        else $error("input data byte does not show pin levels");
    a_flag_upper_zero: assert property (rd_go && I_AVS_ADDRESS == OFS_G0_IRQ_FLAGS
        |=> O_AVS_READDATA[15:8] == 8'h00)
        else $error("flag register upper byte not zero");
    a_g1_irq_zero: assert property (rd_go && (I_AVS_ADDRESS == OFS_G1_IRQ_FLAGS
        || I_AVS_ADDRESS == OFS_G1_DEBOUNCE_ENABLE) |=> O_AVS_READDATA == 32'h0000_0000)
        else $error("group 1 irq or debounce register not zero");
    a_gpio_route: assert property (!g0_peripheral_mode[0]
        |=> O_G0_PIN_OUT[0] == $past(g0_out_value[0]))
        else $error("GPIO path not used with mode bit clear");
    a_g1_no_gpio: assert property (!g1_peripheral_mode[0] |=> !O_G1_PIN_OE[0])
        else $error("group 1 pin 0 driven in GPIO mode");
    a_unassigned_off: assert property (
        g0_peripheral_mode[0] && g0_function_code[1:0] == 2'h2
        |=> !O_G0_PIN_OE[0] && !O_G0_PERIPH_IN[16])
        else $error("unassigned function drives or connects pin");

endmodule : port_group_pin_config

// ==== test/port_group_pin_config_test.sv ====
// Self-checking testbench for the port group pin configuration block
`timescale 1ns/1ps
module port_group_pin_config_test import port_group_pin_config_pkg::*;;
    logic        clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, wreq, irq;
    logic [7:0]  adr = 8'h00, g0_in = 8'h00, g1_in = 8'h00, g0_out, g0_oe, g1_out, g1_oe;
    logic [31:0] wd = 32'h0000_0000, rdata, q, p0i, p0o = 32'h0000_0000, p0e = 32'h0000_0000;
    logic [31:0] p1o = 32'h0000_0000, p1e = 32'h0000_0000;
    logic [31:0] p1i;
    logic [7:0]  pon0, pup0, ib0;
    logic [3:0]  pon1, pup1, ib1;
    int          err_count = 0, checked = 0;
    always #50 clk = ~clk;
    port_group_pin_config #(.DEBOUNCE_DIV(2), .DEBOUNCE_LEN(4)) dut (.I_CLK(clk), .I_RESET(rst),
        .I_AVS_ADDRESS(adr), .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd),
        .I_AVS_BYTEENABLE(4'h3), .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wreq),
        .I_G0_PIN_IN(g0_in), .I_G1_PIN_IN(g1_in), .I_G0_PERIPH_OUT(p0o), .I_G0_PERIPH_OE(p0e),
        .I_G1_PERIPH_OUT(p1o), .I_G1_PERIPH_OE(p1e), .O_G0_PIN_OUT(g0_out), .O_G0_PIN_OE(g0_oe),
        .O_G0_PULL_ON(pon0), .O_G0_PULL_UP(pup0), .O_G0_INBUF_ON(ib0), .O_G1_PIN_OUT(g1_out),
        .O_G1_PIN_OE(g1_oe), .O_G1_PULL_ON(pon1), .O_G1_PULL_UP(pup1), .O_G1_INBUF_ON(ib1),
        .O_G0_PERIPH_IN(p0i), .O_G1_PERIPH_IN(p1i), .O_IRQ(irq));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out
    // Holds the request until waitrequest is sampled low, bounded at 20 edges
    task automatic bus(input logic [7:0] a, input logic w, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk);
        adr <= a;
        rd <= !w;
        wr <= w;
        wd <= {16'h0000, d};
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 20);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (wreq !== 1'b0) begin
            err_count++;
            close_out();
        end
    endtask : bus
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus(a, 1'b0, 16'h0000);
        chk(q, exp);
    endtask : rd_chk
    task automatic t_reset;
        for (int a = 0; a <= 64; a += 4) rd_chk(8'(a), 32'h0000_0000);
        $display("reset values done");
    endtask : t_reset
    task automatic t_gpio;
        bus(OFS_G0_IO_ENABLE, 1'b1, 16'hFFFF);
        bus(OFS_G0_DATA, 1'b1, 16'hA5FF);
        bus(OFS_G1_IO_ENABLE, 1'b1, 16'hFFFF);
        bus(OFS_G1_DATA, 1'b1, 16'hFFFF);
        bus(OFS_G1_IRQ_FLAGS, 1'b1, 16'hFFFF);
        g0_in <= 8'h3C;
        g1_in <= 8'hFF;
        repeat (8) @(posedge clk);
        rd_chk(OFS_G0_DATA, 32'h0000_A53C);
        rd_chk(OFS_G1_DATA, 32'h0000_F0F0);
        rd_chk(OFS_G1_IO_ENABLE, 32'h0000_F0F0);
        rd_chk(OFS_G1_IRQ_FLAGS, 32'h0000_0000);
        chk({g0_oe, g0_out}, 32'h0000_FFA5);
        chk(g1_oe, 32'h0000_00F0);
        bus(OFS_G0_PULL_CONTROL, 1'b1, 16'h5AC3);
        bus(OFS_G1_PULL_CONTROL, 1'b1, 16'hAF5F);
        rd_chk(OFS_G0_PULL_CONTROL, 32'h0000_5AC3);
        rd_chk(OFS_G1_PULL_CONTROL, 32'h0000_A050);
        chk({pup0, pon0, ib0}, 32'h005A_C3FF);
        chk({pup1, pon1, ib1}, 32'h0000_0A5F);
        $display("gpio done");
    endtask : t_gpio
    task automatic t_irq;
        bus(OFS_G0_IRQ_FLAGS, 1'b1, 16'h00FF);
        bus(OFS_G0_IRQ_CONTROL, 1'b1, 16'h0201);
        g0_in <= 8'h3F;
        repeat (8) @(posedge clk);
        g0_in <= 8'h3D;
        repeat (8) @(posedge clk);
        chk(irq, 1'b1);
        bus(OFS_G0_IRQ_FLAGS, 1'b1, 16'hFF00);
        rd_chk(OFS_G0_IRQ_FLAGS, 32'h0000_0003);
        bus(OFS_G0_IRQ_FLAGS, 1'b1, 16'h0001);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        rd_chk(OFS_G0_IRQ_FLAGS, 32'h0000_0002);
        $display("interrupt done");
    endtask : t_irq
    // A short pulse on pins 6 and 7: only the unfiltered pin 6 may flag it
    task automatic t_filter;
        bus(OFS_G0_DEBOUNCE_ENABLE, 1'b1, 16'hFF80);
        rd_chk(OFS_G0_DEBOUNCE_ENABLE, 32'h0000_0080);
        bus(OFS_G0_IRQ_FLAGS, 1'b1, 16'h00FF);
        g0_in <= 8'hFD;
        repeat (2) @(posedge clk);
        g0_in <= 8'h3D;
        repeat (8) @(posedge clk);
        rd_chk(OFS_G0_IRQ_FLAGS, 32'h0000_0040);
        g0_in <= 8'hBD;
        repeat (24) @(posedge clk);
        rd_chk(OFS_G0_IRQ_FLAGS, 32'h0000_00C0);
        chk(irq, 1'b0);
        $display("filter done");
    endtask : t_filter
    task automatic t_mux;
        p0e <= 32'h0100_0000;
        p1o <= 32'h0000_0001;
        p1e <= 32'h0000_0001;
        bus(OFS_G0_FUNCTION_SELECT, 1'b1, 16'h0003);
        bus(OFS_G0_MODE_SELECT, 1'b1, 16'hFF01);
        rd_chk(OFS_G0_MODE_SELECT, 32'h0000_0001);
        chk({g0_oe[0], g0_out[0], p0i[24]}, 3'b101);
        bus(OFS_G0_FUNCTION_SELECT, 1'b1, 16'h0002);
        repeat (2) @(posedge clk);
        chk(g0_oe[0], 1'b0);
        bus(OFS_G1_MODE_SELECT, 1'b1, 16'hFFFF);
        bus(OFS_G1_FUNCTION_SELECT, 1'b1, 16'hFFFC);
        rd_chk(OFS_G1_MODE_SELECT, 32'h0000_00FF);
        rd_chk(OFS_G1_FUNCTION_SELECT, 32'h0000_FFFC);
        chk({g1_oe[0], g1_out[0], p1i[0]}, 3'b111);
        $display("routing done");
    endtask : t_mux
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_gpio();
        t_irq();
        t_filter();
        t_mux();
        close_out();
    end
endmodule : port_group_pin_config_test
